// ---- core/cfg_router_pkg.sv ----
/*
 * Constants, types and field layout for the configuration cycle router.
 * Assumes a single host clock domain; all users import the whole package.
 */
// Function
// - Bus 0 access to a present internal device is claimed by that device.
// - Header byte 8 holds bus, byte 9 holds device and function.
// - Header byte 10 low nibble holds extended register, byte 11 bits 7:2 register.
// - Bus equal to secondary bus gives type 0 packet on graphics link.
// - Type 0 graphics access to non-zero device ends in master abort.
// - Bus above secondary, up to subordinate, gives type 1 graphics packet.
// - Memory-mapped config writes to graphics or hub link complete posted at host, non-posted downstream.
// - Disabled devices, foreign buses, non-internal bus 0 devices go to hub link.
// - Hub link access with bus zero uses a type 0 packet.
// - Hub link access with non-zero bus outside bridge range uses type 1.
// - Unclaimed downstream config access returns master abort to the processor.
// - Compatible and extended accesses to graphics port both go to that port.
// - Index register sits at I/O 0CF8h, claimed only for full doubleword access.
// - Byte or word accesses at the index address pass to hub as I/O.
// - Index bit 31 enables config window; resets to zero.
// - Data window access makes a config cycle only while bit 31 set.
// - Internal device config cycles with function above 1 are ignored.
// - Bus 0 devices 0, 1, 2 are host bridge, graphics bridge, graphics.
package cfg_router_pkg;

	////////////////////////////////////////////////////////////////////////////////
	// I/O addresses and index register
	localparam logic [31:0] CFG_INDEX_ADDR = 32'h0000_0cf8;
	localparam logic [31:0] CFG_DATA_ADDR = 32'h0000_0cfc;
	localparam logic [31:0] CFG_INDEX_RESET = 32'h0000_0000;
	localparam logic [31:0] CFG_INDEX_RW_MASK = 32'h80ff_fffc;
	localparam logic [3:0] BE_DWORD = 4'hf;
	localparam logic [31:0] ABORT_RDATA = 32'hffff_ffff;

	////////////////////////////////////////////////////////////////////////////////
	// Field positions in the index register
	localparam int IDX_EN_BIT = 31;
	localparam int IDX_BUS_LSB = 16;
	localparam int IDX_DEV_LSB = 11;
	localparam int IDX_FN_LSB = 8;
	localparam int IDX_REG_LSB = 2;

	// Field positions in a memory-mapped configuration address
	localparam int MM_WIN_LSB = 28;
	localparam int MM_BUS_LSB = 20;
	localparam int MM_DEV_LSB = 15;
	localparam int MM_FN_LSB = 12;
	localparam int MM_EXT_LSB = 8;
	localparam int MM_REG_LSB = 2;

	// Header bytes 8..11 packed as one word, byte 8 in the top lane
	localparam int HDR_BUS_LSB = 24;
	localparam int HDR_DEV_LSB = 19;
	localparam int HDR_FN_LSB = 16;
	localparam int HDR_EXT_LSB = 8;
	localparam int HDR_REG_LSB = 2;

	////////////////////////////////////////////////////////////////////////////////
	// Bus 0 device numbers
	localparam logic [4:0] DEV_HOST_BRIDGE = 5'h00;
	localparam logic [4:0] DEV_GFX_BRIDGE = 5'h01;
	localparam logic [4:0] DEV_GFX_CORE = 5'h02;
	localparam logic [2:0] FN_MAX_INTERNAL = 3'h1;

	typedef enum {ST_IDLE, ST_WAIT} router_state_t;
	typedef enum {RT_INDEX_WR, RT_INDEX_RD, RT_HUB_IO, RT_INTERNAL, RT_GFX, RT_HUB_CFG,
		RT_ABORT} route_t;

endpackage

// ---- core/config_cycle_router.sv ----
/*
 * Configuration cycle router: index register, data window and memory-mapped
 * decode, routing to internal devices, the graphics link or the hub link.
 * Assumes one outstanding request; the chosen target answers on the shared
 * completion port. Bridge bus numbers and device enables come from elsewhere.
 */
`timescale 1ns/1ns
module config_cycle_router
	import cfg_router_pkg::*;
(
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic i_clk_en,
	// Host bus request
	input wire logic i_req_valid,
	input wire logic i_req_io,
	input wire logic i_req_write,
	input wire logic [31:0] i_req_addr,
	input wire logic [3:0] i_req_be,
	input wire logic [31:0] i_req_wdata,
	output logic o_req_ready,
	// Host bus answer
	output logic o_rsp_valid,
	output logic o_rsp_abort,
	output logic [31:0] o_rsp_rdata,
	// Configuration from the bridge and device registers
	input wire logic i_mm_enable,
	input wire logic [3:0] i_mm_base,
	input wire logic [7:0] i_sec_bus,
	input wire logic [7:0] i_sub_bus,
	input wire logic i_gfx_bridge_enable,
	input wire logic i_gfx_core_enable,
	// Downstream request
	output logic o_int_valid,
	output logic o_gfx_valid,
	output logic o_hub_valid,
	output logic o_hub_io,
	output logic o_cfg_type1,
	output logic o_cfg_write,
	output logic [31:0] o_cfg_hdr,
	output logic [31:0] o_fwd_addr,
	output logic [3:0] o_fwd_be,
	output logic [31:0] o_fwd_wdata,
	// Shared completion
	input wire logic i_cpl_valid,
	input wire logic i_cpl_abort,
	input wire logic [31:0] i_cpl_rdata,
	// Index register view
	output logic o_config_window_enable
);

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	logic [31:0] config_index;
	router_state_t state;
	logic posted;
	logic accept;
	logic win_hit;
	logic mm_hit;
	logic [7:0] dbus;
	logic [4:0] ddev;
	logic [2:0] dfn;
	logic [3:0] dext;
	logic [5:0] dreg;
	logic dev_present;
	logic in_range;
	logic [31:0] hdr;
	route_t route;

	assign accept = i_req_valid && o_req_ready && i_clk_en;
	assign win_hit = i_req_io && i_req_addr == CFG_DATA_ADDR && config_index[IDX_EN_BIT];
	assign mm_hit = !i_req_io && i_mm_enable && i_req_addr[MM_WIN_LSB +: 4] == i_mm_base;

	always_comb begin
		if (mm_hit) begin
			dbus = i_req_addr[MM_BUS_LSB +: 8];
			ddev = i_req_addr[MM_DEV_LSB +: 5];
			dfn = i_req_addr[MM_FN_LSB +: 3];
			dext = i_req_addr[MM_EXT_LSB +: 4];
			dreg = i_req_addr[MM_REG_LSB +: 6];
		end else begin
			dbus = config_index[IDX_BUS_LSB +: 8];
			ddev = config_index[IDX_DEV_LSB +: 5];
			dfn = config_index[IDX_FN_LSB +: 3];
			dext = 4'h0;
			dreg = config_index[IDX_REG_LSB +: 6];
		end
	end

	config_header_pack u_hdr (
		.i_bus(dbus),
		.i_dev(ddev),
		.i_fn(dfn),
		.i_ext(dext),
		.i_reg(dreg),
		.o_hdr(hdr)
	);

	assign dev_present = ddev == DEV_HOST_BRIDGE
		|| (ddev == DEV_GFX_BRIDGE && i_gfx_bridge_enable)
		|| (ddev == DEV_GFX_CORE && i_gfx_core_enable);
	assign in_range = i_gfx_bridge_enable && dbus >= i_sec_bus && dbus <= i_sub_bus;

	always_comb begin
		route = RT_HUB_IO;
		if (i_req_io && i_req_addr == CFG_INDEX_ADDR && i_req_be == BE_DWORD) begin
			route = i_req_write ? RT_INDEX_WR : RT_INDEX_RD;
		end else if (win_hit || mm_hit) begin
			if (dbus == 8'h00) begin
				if (dev_present) begin
					route = (dfn > FN_MAX_INTERNAL) ? RT_ABORT : RT_INTERNAL;
				end else begin
					route = RT_HUB_CFG;
				end
			end else if (in_range && dbus == i_sec_bus) begin
				route = (ddev != 5'h00) ? RT_ABORT : RT_GFX;
			end else if (in_range) begin
				route = RT_GFX;
			end else begin
				route = RT_HUB_CFG;
			end
		end else if (!i_req_io) begin
			route = RT_ABORT;
		end
		// Byte/word index, disabled window and other I/O stay RT_HUB_IO
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	logic [31:0] next_config_index;
	router_state_t next_state;
	logic next_posted;
	logic next_ready;
	logic next_rsp_valid;
	logic next_rsp_abort;
	logic [31:0] next_rsp_rdata;
	logic next_int_valid;
	logic next_gfx_valid;
	logic next_hub_valid;
	logic next_hub_io;
	logic next_type1;
	logic next_write;
	logic [31:0] next_hdr;
	logic [31:0] next_addr;
	logic [3:0] next_be;
	logic [31:0] next_wdata;

	always_comb begin
		next_config_index = config_index;
		next_state = state;
		next_posted = posted;
		next_rsp_valid = 1'b0;
		next_rsp_abort = 1'b0;
		next_rsp_rdata = o_rsp_rdata;
		next_int_valid = 1'b0;
		next_gfx_valid = 1'b0;
		next_hub_valid = 1'b0;
		next_hub_io = o_hub_io;
		next_type1 = o_cfg_type1;
		next_write = o_cfg_write;
		next_hdr = o_cfg_hdr;
		next_addr = o_fwd_addr;
		next_be = o_fwd_be;
		next_wdata = o_fwd_wdata;
		case (state)
			ST_IDLE: begin
				if (accept) begin
					next_write = i_req_write;
					next_hdr = hdr;
					next_addr = i_req_addr;
					next_be = i_req_be;
					next_wdata = i_req_wdata;
					next_hub_io = 1'b0;
					next_type1 = 1'b0;
					next_posted = 1'b0;
					case (route)
						RT_INDEX_WR: begin
							next_config_index = i_req_wdata & CFG_INDEX_RW_MASK;
							next_rsp_valid = 1'b1;
							next_rsp_rdata = 32'h0000_0000;
						end
						RT_INDEX_RD: begin
							next_rsp_valid = 1'b1;
							next_rsp_rdata = config_index;
						end
						RT_ABORT: begin
							next_rsp_valid = 1'b1;
							next_rsp_abort = 1'b1;
							next_rsp_rdata = ABORT_RDATA;
						end
						RT_INTERNAL: begin
							next_int_valid = 1'b1;
							next_state = ST_WAIT;
						end
						RT_GFX: begin
							next_gfx_valid = 1'b1;
							next_type1 = dbus != i_sec_bus;
							next_state = ST_WAIT;
						end
						RT_HUB_CFG: begin
							next_hub_valid = 1'b1;
							next_type1 = dbus != 8'h00;
							next_state = ST_WAIT;
						end
						default: begin
							next_hub_valid = 1'b1;
							next_hub_io = 1'b1;
							next_state = ST_WAIT;
						end
					endcase
					// Host sees the write done now; downstream still waits for its completion
					if (mm_hit && i_req_write && (route == RT_GFX || route == RT_HUB_CFG)) begin
						next_posted = 1'b1;
						next_rsp_valid = 1'b1;
						next_rsp_rdata = 32'h0000_0000;
					end
				end
			end
			ST_WAIT: begin
				if (i_cpl_valid) begin
					next_state = ST_IDLE;
					next_posted = 1'b0;
					if (!posted) begin
						next_rsp_valid = 1'b1;
						next_rsp_abort = i_cpl_abort;
						next_rsp_rdata = i_cpl_abort ? ABORT_RDATA : i_cpl_rdata;
					end
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
		next_ready = next_state == ST_IDLE;
	end

	////////////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			config_index <= CFG_INDEX_RESET;
			state <= ST_IDLE;
			posted <= 1'b0;
			o_req_ready <= 1'b1;
			o_rsp_valid <= 1'b0;
			o_rsp_abort <= 1'b0;
			o_rsp_rdata <= 32'h0000_0000;
			o_int_valid <= 1'b0;
			o_gfx_valid <= 1'b0;
			o_hub_valid <= 1'b0;
			o_hub_io <= 1'b0;
			o_cfg_type1 <= 1'b0;
			o_cfg_write <= 1'b0;
			o_cfg_hdr <= 32'h0000_0000;
			o_fwd_addr <= 32'h0000_0000;
			o_fwd_be <= 4'h0;
			o_fwd_wdata <= 32'h0000_0000;
			o_config_window_enable <= 1'b0;
		end else if (i_clk_en) begin
			config_index <= next_config_index;
			state <= next_state;
			posted <= next_posted;
			o_req_ready <= next_ready;
			o_rsp_valid <= next_rsp_valid;
			o_rsp_abort <= next_rsp_abort;
			o_rsp_rdata <= next_rsp_rdata;
			o_int_valid <= next_int_valid;
			o_gfx_valid <= next_gfx_valid;
			o_hub_valid <= next_hub_valid;
			o_hub_io <= next_hub_io;
			o_cfg_type1 <= next_type1;
			o_cfg_write <= next_write;
			o_cfg_hdr <= next_hdr;
			o_fwd_addr <= next_addr;
			o_fwd_be <= next_be;
			o_fwd_wdata <= next_wdata;
			o_config_window_enable <= next_config_index[IDX_EN_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (i_rst);

	AST_INDEX_DWORD_WRITE: assert property (
		accept && route == RT_INDEX_WR |=> config_index == ($past(i_req_wdata) & CFG_INDEX_RW_MASK)
	) else $error("index write not stored");
	AST_INDEX_PARTIAL_PASS: assert property (
		accept && i_req_io && i_req_addr == CFG_INDEX_ADDR && i_req_be != BE_DWORD
		|=> o_hub_valid && o_hub_io && !o_rsp_valid
	) else $error("partial index access not passed to hub");
	AST_WINDOW_DISABLED: assert property (
		accept && i_req_io && i_req_addr == CFG_DATA_ADDR && !config_index[IDX_EN_BIT]
		|=> o_hub_io && !o_int_valid && !o_gfx_valid
	) else $error("config cycle made with window disabled");
	AST_GFX_TYPE0_DEV0: assert property (
		o_gfx_valid && !o_cfg_type1 |-> o_cfg_hdr[HDR_DEV_LSB +: 5] == 5'h00
	) else $error("graphics type 0 to non-zero device");
	AST_HUB_TYPE: assert property (
		o_hub_valid && !o_hub_io |-> o_cfg_type1 == (o_cfg_hdr[HDR_BUS_LSB +: 8] != 8'h00)
	) else $error("hub packet type does not match bus");
	AST_INT_FUNCTION: assert property (
		o_int_valid |-> o_cfg_hdr[HDR_FN_LSB +: 3] <= FN_MAX_INTERNAL
			&& o_cfg_hdr[HDR_BUS_LSB +: 8] == 8'h00
	) else $error("internal claim with bad function or bus");
	AST_POSTED_WRITE: assert property (
		(o_gfx_valid || o_hub_valid) && posted |-> o_rsp_valid && o_cfg_write && !o_rsp_abort
	) else $error("posted write not completed at host");
	AST_ABORT_RETURN: assert property (
		i_clk_en && state == ST_WAIT && i_cpl_valid && i_cpl_abort && !posted
		|=> o_rsp_valid && o_rsp_abort && o_rsp_rdata == ABORT_RDATA
			##1 (!o_rsp_valid || $past(accept) || !$past(i_clk_en))
	) else $error("master abort not returned");
	AST_HDR_RESERVED: assert property (
		o_gfx_valid || (o_hub_valid && !o_hub_io) |-> o_cfg_hdr[15:12] == 4'h0
			&& o_cfg_hdr[1:0] == 2'b00
	) else $error("reserved header bits set");

	COV_GFX_TYPE1: cover property (o_gfx_valid && o_cfg_type1);
	COV_HUB_TYPE0: cover property (o_hub_valid && !o_hub_io && !o_cfg_type1);
	COV_POSTED: cover property (o_rsp_valid && posted);
	COV_INTERNAL: cover property (o_int_valid);

endmodule

// ---- core/config_header_pack.sv ----
/*
 * Packs bus, device, function and register numbers into header bytes 8..11.
 * Purely combinational; the caller registers the result.
 */
`timescale 1ns/1ns
module config_header_pack
	import cfg_router_pkg::*;
(
	// Fields
	input wire logic [7:0] i_bus,
	input wire logic [4:0] i_dev,
	input wire logic [2:0] i_fn,
	input wire logic [3:0] i_ext,
	input wire logic [5:0] i_reg,
	// Packed header bytes 8..11
	output logic [31:0] o_hdr
);

	always_comb begin
		o_hdr = 32'h0000_0000;
		o_hdr[HDR_BUS_LSB +: 8] = i_bus;
		o_hdr[HDR_DEV_LSB +: 5] = i_dev;
		o_hdr[HDR_FN_LSB +: 3] = i_fn;
		o_hdr[HDR_EXT_LSB +: 4] = i_ext;
		o_hdr[HDR_REG_LSB +: 6] = i_reg;
	end

endmodule

// ---- testbench/config_target_model.sv ----
/*
 * Far-side target model: internal devices, graphics link and hub link
 * all answer through one completion port after a programmable delay.
 * Assumes the router keeps at most one request outstanding.
 */
`timescale 1ns/1ns
module config_target_model (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst,
	// Request seen and test controls
	input wire logic i_req_seen,
	input wire logic i_write,
	input wire logic [31:0] i_addr,
	input wire logic [3:0] i_lat,
	input wire logic i_abort_mode,
	// Completion
	output logic o_cpl_valid,
	output logic o_cpl_abort,
	output logic [31:0] o_cpl_rdata
);
	logic [3:0] cnt;
	logic busy;
	logic wr;
	logic [31:0] addr;
	logic [31:0] noise;

	always_ff @(posedge i_sys_clk or posedge i_rst) begin
		if (i_rst) begin
			cnt <= 4'h0;
			busy <= 1'b0;
			wr <= 1'b0;
			addr <= 32'h0;
			noise <= 32'h0;
		end else begin
			noise <= noise + 32'h1357_9bdf;
			if (i_req_seen) begin
				busy <= 1'b1;
				cnt <= i_lat;
				wr <= i_write;
				addr <= i_addr;
			end else if (busy && cnt == 4'h0) begin
				busy <= 1'b0;
			end else if (busy) begin
				cnt <= cnt - 4'h1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Idle lines toggle so a stale value can never pass for an answer
	assign o_cpl_valid = busy && cnt == 4'h0;
	assign o_cpl_abort = o_cpl_valid ? i_abort_mode : noise[0];
	// Write completions carry no data
	assign o_cpl_rdata = o_cpl_valid ? (wr ? 32'h0 : addr ^ 32'h5a5a_5a5a) : ~noise;
endmodule

// ---- testbench/testbench.sv ----
/*
 * Self-checking bench for the configuration cycle router.
 * Assumes the target model answers every downstream request.
 */
`timescale 1ns/1ns
module testbench;
	import cfg_router_pkg::*;
	logic clk = 1'b0, rst = 1'b1;
	logic rq_v = 1'b0, rq_io = 1'b0, rq_wr = 1'b0;
	logic [31:0] rq_a = 32'h0, rq_d = 32'h0;
	logic [3:0] rq_be = 4'h0, lat = 4'h2, mm_base = 4'he;
	logic mm_en = 1'b1, br_en = 1'b1, core_en = 1'b1, ab_mode = 1'b0, cken = 1'b1;
	logic [7:0] sec = 8'h05, sub = 8'h08;
	logic rdy, rsp_v, rsp_ab, int_v, gfx_v, hub_v, hub_io, t1, cwr, win_en, cpl_v, cpl_ab;
	logic [31:0] rsp_d, hdr, f_a, f_d, cpl_d;
	logic [3:0] f_be;
	logic [1:0] g_rt;
	logic g_t1, g_io, g_wr, g_ab;
	logic [31:0] g_hdr, g_d;
	int failures = 0, checks = 0, cycles = 0, g_n;

	config_cycle_router dut_u (.i_sys_clk(clk), .i_rst(rst), .i_clk_en(cken),
		.i_req_valid(rq_v), .i_req_io(rq_io), .i_req_write(rq_wr), .i_req_addr(rq_a),
		.i_req_be(rq_be), .i_req_wdata(rq_d), .o_req_ready(rdy), .o_rsp_valid(rsp_v),
		.o_rsp_abort(rsp_ab), .o_rsp_rdata(rsp_d), .i_mm_enable(mm_en), .i_mm_base(mm_base),
		.i_sec_bus(sec), .i_sub_bus(sub), .i_gfx_bridge_enable(br_en),
		.i_gfx_core_enable(core_en), .o_int_valid(int_v), .o_gfx_valid(gfx_v),
		.o_hub_valid(hub_v), .o_hub_io(hub_io), .o_cfg_type1(t1), .o_cfg_write(cwr),
		.o_cfg_hdr(hdr), .o_fwd_addr(f_a), .o_fwd_be(f_be), .o_fwd_wdata(f_d),
		.i_cpl_valid(cpl_v), .i_cpl_abort(cpl_ab), .i_cpl_rdata(cpl_d),
		.o_config_window_enable(win_en));

	config_target_model partner_u (.i_sys_clk(clk), .i_rst(rst),
		.i_req_seen(int_v | gfx_v | hub_v), .i_write(cwr), .i_addr(f_a), .i_lat(lat),
		.i_abort_mode(ab_mode), .o_cpl_valid(cpl_v), .o_cpl_abort(cpl_ab),
		.o_cpl_rdata(cpl_d));

	always #2 clk = ~clk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic wrap_up();
		if (failures == 0 && checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Ceiling well above the few hundred cycles the sequence needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 4000) begin
			failures++;
			wrap_up();
		end
	end

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Request held until an edge samples ready high
	task automatic access(input logic io, input logic wr, input logic [31:0] a,
		input logic [3:0] be, input logic [31:0] d);
		int n;
		n = 0;
		@(negedge clk);
		rq_v = 1'b1;
		rq_io = io;
		rq_wr = wr;
		rq_a = a;
		rq_be = be;
		rq_d = d;
		@(posedge clk);
		while (rdy !== 1'b1 && n < 100) begin
			n++;
			@(posedge clk);
		end
		g_rt = 2'd0;
		g_io = 1'b0;
		g_n = 0;
		do begin
			@(negedge clk);
			rq_v = 1'b0;
			g_n++;
			if ((int_v | gfx_v | hub_v) === 1'b1) begin
				g_rt = int_v ? 2'd1 : (gfx_v ? 2'd2 : 2'd3);
				g_io = hub_io;
				g_t1 = t1;
				g_wr = cwr;
				g_hdr = hdr;
			end
		end while (rsp_v !== 1'b1 && g_n < 100);
		g_ab = rsp_ab;
		g_d = rsp_d;
		check("answer", 32'(rsp_v), 32'h1);
	endtask

	task automatic cfg(input logic mm, input logic wr, input logic [7:0] bus,
		input logic [4:0] dev, input logic [2:0] fn, input logic [3:0] ext,
		input logic [5:0] rg, input logic [1:0] rt, input logic typ1);
		logic [31:0] a;
		logic ab;
		a = {mm_base, bus, dev, fn, ext, rg, 2'b00};
		if (!mm) begin
			access(1'b1, 1'b1, CFG_INDEX_ADDR, BE_DWORD, {1'b1, 7'h00, bus, dev, fn, rg, 2'b00});
			a = CFG_DATA_ADDR;
		end
		ab = rt == 2'd0 || ab_mode;
		access(!mm, wr, a, BE_DWORD, a ^ 32'hc3c3_0000);
		check("route", {29'h0, g_rt, g_io}, {29'h0, rt, 1'b0});
		if (rt != 2'd0) begin
			check("header", g_hdr, {bus, dev, fn, 4'h0, mm ? ext : 4'h0, rg, 2'b00});
			check("type1", 32'(g_t1), 32'(typ1));
			check("cfg_write", 32'(g_wr), 32'(wr));
			check("fwd_data", f_d, a ^ 32'hc3c3_0000);
		end
		check("abort", 32'(g_ab), 32'(ab));
		check("rdata", g_d, ab ? 32'hffff_ffff : (wr ? 32'h0 : a ^ 32'h5a5a_5a5a));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(negedge clk);
		rst = 1'b0;
		access(1'b1, 1'b0, CFG_INDEX_ADDR, BE_DWORD, 32'h0);
		check("index", g_d, 32'h0);
		check("enable", 32'(win_en), 32'h0);
		access(1'b1, 1'b0, CFG_DATA_ADDR, BE_DWORD, 32'h0);
		check("window_io", {29'h0, g_rt, g_io}, 32'h7);
		access(1'b1, 1'b1, CFG_INDEX_ADDR, 4'h3, 32'h8000_0000);
		check("byte_io", {29'h0, g_rt, g_io}, 32'h7);
		check("byte_be", 32'(f_be), 32'h3);
		access(1'b1, 1'b0, CFG_INDEX_ADDR, BE_DWORD, 32'h0);
		check("index", g_d, 32'h0);
		check("enable", 32'(win_en), 32'h0);
		access(1'b1, 1'b1, CFG_INDEX_ADDR, BE_DWORD, 32'hffff_ffff);
		check("enable", 32'(win_en), 32'h1);
		access(1'b1, 1'b0, CFG_INDEX_ADDR, BE_DWORD, 32'h0);
		check("index", g_d, 32'h80ff_fffc);
		access(1'b1, 1'b1, CFG_INDEX_ADDR + 32'h1, BE_DWORD, 32'h0);
		check("other_io", {29'h0, g_rt, g_io}, 32'h7);
		access(1'b1, 1'b0, CFG_DATA_ADDR - 32'h1, BE_DWORD, 32'h0);
		check("other_io", {29'h0, g_rt, g_io}, 32'h7);
		access(1'b1, 1'b1, CFG_INDEX_ADDR - 32'h1, BE_DWORD, 32'h0);
		check("other_io", {29'h0, g_rt, g_io}, 32'h7);
		access(1'b1, 1'b1, ~CFG_INDEX_ADDR, BE_DWORD, 32'h0);
		check("other_io", {29'h0, g_rt, g_io}, 32'h7);
		access(1'b1, 1'b1, ~CFG_DATA_ADDR, BE_DWORD, 32'h0);
		check("other_io", {29'h0, g_rt, g_io}, 32'h7);
		access(1'b1, 1'b0, CFG_INDEX_ADDR, BE_DWORD, 32'h0);
		check("index", g_d, 32'h80ff_fffc);
		// Memory cycle outside the window answers abort locally
		access(1'b0, 1'b0, 32'h1000_0000, BE_DWORD, 32'h0);
		check("mem_route", 32'(g_rt), 32'h0);
		check("mem_abort", 32'(g_ab), 32'h1);
		check("mem_rdata", g_d, 32'hffff_ffff);
		// Index write held while the clock enable is low
		@(negedge clk);
		cken = 1'b0;
		rq_v = 1'b1;
		rq_io = 1'b1;
		rq_wr = 1'b1;
		rq_a = CFG_INDEX_ADDR;
		rq_be = BE_DWORD;
		rq_d = 32'h0;
		repeat (3) @(negedge clk);
		check("frozen", 32'(win_en), 32'h1);
		check("frozen_rsp", 32'(rsp_v), 32'h0);
		cken = 1'b1;
		@(negedge clk);
		rq_v = 1'b0;
		check("thawed_rsp", 32'(rsp_v), 32'h1);
		check("enable", 32'(win_en), 32'h0);
		access(1'b1, 1'b0, CFG_INDEX_ADDR, BE_DWORD, 32'h0);
		check("index", g_d, 32'h0);
		cfg(0, 0, 8'h00, 5'h00, 3'h0, 4'h0, 6'h01, 2'd1, 0);
		cfg(0, 0, 8'h00, 5'h01, 3'h1, 4'h0, 6'h02, 2'd1, 0);
		cfg(0, 1, 8'h00, 5'h02, 3'h0, 4'h0, 6'h03, 2'd1, 0);
		cfg(0, 0, 8'h00, 5'h02, 3'h2, 4'h0, 6'h04, 2'd0, 0);
		cfg(0, 0, 8'h00, 5'h03, 3'h0, 4'h0, 6'h05, 2'd3, 0);
		cfg(0, 0, 8'h05, 5'h00, 3'h3, 4'h0, 6'h06, 2'd2, 0);
		cfg(0, 0, 8'h05, 5'h01, 3'h0, 4'h0, 6'h07, 2'd0, 0);
		cfg(0, 0, 8'h06, 5'h04, 3'h1, 4'h0, 6'h08, 2'd2, 1);
		cfg(0, 0, 8'h08, 5'h1f, 3'h7, 4'h0, 6'h3f, 2'd2, 1);
		cfg(0, 0, 8'h09, 5'h00, 3'h0, 4'h0, 6'h09, 2'd3, 1);
		core_en = 1'b0;
		cfg(0, 0, 8'h00, 5'h02, 3'h0, 4'h0, 6'h0a, 2'd3, 0);
		br_en = 1'b0;
		cfg(0, 0, 8'h00, 5'h01, 3'h0, 4'h0, 6'h0b, 2'd3, 0);
		br_en = 1'b1;
		lat = 4'h6;
		cfg(1, 0, 8'h05, 5'h00, 3'h0, 4'ha, 6'h3f, 2'd2, 0);
		cfg(1, 1, 8'h09, 5'h02, 3'h3, 4'h5, 6'h10, 2'd3, 1);
		check("posted", 32'(g_n), 32'h1);
		ab_mode = 1'b1;
		cfg(0, 0, 8'h09, 5'h01, 3'h0, 4'h0, 6'h0c, 2'd3, 1);
		ab_mode = 1'b0;
		wrap_up();
	end
endmodule
